// file: hw/host_port_pkg.sv
// Constants and types for the display module host port
package host_port_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned SER_BITS = 8;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [2:0] BIT_COUNT_RESET = 3'h0;
  localparam int unsigned SER_DATA_POS = 1;
  localparam int unsigned SER_CLK_POS = 0;

  typedef enum logic [2:0] {
    MODE_SERIAL = 3'b001,
    MODE_P68 = 3'b010,
    MODE_P80 = 3'b100
  } bus_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ = 3'b100
  } xfer_state_t;
endpackage

// file: hw/display_module_host_port.sv
// Host bus port: parallel 68XX/80XX and serial byte receiver
module display_module_host_port (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        reset_n,
  input  wire logic        bus_mode_strap_a,
  input  wire logic        bus_mode_strap_b,
  input  wire logic        select_n,
  input  wire logic        read_strobe,
  input  wire logic        write_strobe,
  input  wire logic        data_command_select,
  input  wire logic [7:0]  host_data_bus_in,
  output logic      [7:0]  host_data_bus_out,
  output logic      [7:0]  host_data_bus_oe,
  input  wire logic [7:0]  read_data,
  output logic             read_take,
  output logic      [7:0]  rx_byte,
  output logic             rx_data_valid,
  output logic             rx_command_valid,
  output logic             init_active
);
  host_port_pkg::bus_mode_t   mode_reg, mode_next;
  logic                       mode_loaded_reg, mode_loaded_next;
  host_port_pkg::xfer_state_t state_reg, state_next;
  logic [7:0]                 shift_reg, shift_next;
  logic [2:0]                 count_reg, count_next;
  logic                       sclk_prev_reg, sclk_prev_next;
  logic [7:0]                 out_reg, out_next;
  logic [7:0]                 oe_reg, oe_next;
  logic                       take_reg, take_next;
  logic [7:0]                 byte_reg, byte_next;
  logic                       dval_reg, dval_next;
  logic                       cval_reg, cval_next;
  logic                       init_reg, init_next;
  logic                       in_reset;
  logic                       p_active;
  logic                       p_read;
  logic                       sclk;
  logic                       sclk_rise;
  logic                       serial_on;
  logic                       parallel_on;
  logic [7:0]                 hold_reg, hold_next;
  logic [7:0]                 ser_byte;
  logic                       ser_done;
  logic                       par_wr_done;
  logic                       par_rd_start;
  logic                       par_rd_end;

  function automatic host_port_pkg::bus_mode_t decode_mode(input logic a, input logic b);
    // Straps: a high with b low selects 68XX, b high selects 80XX, both low serial
    if (a && !b) begin
      decode_mode = host_port_pkg::MODE_P68;
    end else if (b) begin
      decode_mode = host_port_pkg::MODE_P80;
    end else begin
      decode_mode = host_port_pkg::MODE_SERIAL;
    end
  endfunction

  assign in_reset = rst || !reset_n;
  assign sclk = host_data_bus_in[host_port_pkg::SER_CLK_POS];

  always_comb begin
    p_active = 1'b0;
    p_read = 1'b0;
    if (mode_reg == host_port_pkg::MODE_P68) begin
      p_active = read_strobe && !select_n;
      p_read = write_strobe;
    end else if (mode_reg == host_port_pkg::MODE_P80) begin
      p_active = (!read_strobe || !write_strobe) && !select_n;
      p_read = !read_strobe;
    end
  end

  assign sclk_rise = sclk && !sclk_prev_reg;
  assign serial_on = mode_loaded_reg && (mode_reg == host_port_pkg::MODE_SERIAL);
  assign parallel_on = mode_loaded_reg && (mode_reg != host_port_pkg::MODE_SERIAL);

  // Mode group
  always_comb begin
    mode_next = mode_reg;
    mode_loaded_next = mode_loaded_reg;
    // Straps are caught once after reset release, never at run time
    if (!mode_loaded_reg) begin
      mode_next = decode_mode(bus_mode_strap_a, bus_mode_strap_b);
      mode_loaded_next = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (in_reset) begin
      mode_reg <= host_port_pkg::MODE_SERIAL;
      mode_loaded_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      mode_loaded_reg <= mode_loaded_next;
    end
  end

  // Serial receiver group
  always_comb begin
    shift_next = shift_reg;
    count_next = count_reg;
    sclk_prev_next = sclk;
    ser_done = 1'b0;
    ser_byte = {shift_reg[6:0], host_data_bus_in[host_port_pkg::SER_DATA_POS]};
    if (serial_on) begin
      if (select_n) begin
        // Partial byte is dropped when the host deselects
        count_next = host_port_pkg::BIT_COUNT_RESET;
      end else if (sclk_rise) begin
        // MSB first on each serial clock rising edge
        shift_next = ser_byte;
        count_next = count_reg + 3'h1;
        if (count_reg == 3'(host_port_pkg::SER_BITS - 1)) begin
          ser_done = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (in_reset) begin
      shift_reg <= host_port_pkg::DATA_RESET;
      count_reg <= host_port_pkg::BIT_COUNT_RESET;
      sclk_prev_reg <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      count_reg <= count_next;
      sclk_prev_reg <= sclk_prev_next;
    end
  end

  // Parallel transfer group
  always_comb begin
    state_next = state_reg;
    hold_next = hold_reg;
    par_wr_done = 1'b0;
    par_rd_start = 1'b0;
    par_rd_end = 1'b0;
    if (parallel_on) begin
      case (state_reg)
        host_port_pkg::ST_IDLE: begin
          if (p_active && p_read) begin
            state_next = host_port_pkg::ST_READ;
            par_rd_start = 1'b1;
          end else if (p_active) begin
            state_next = host_port_pkg::ST_WRITE;
            hold_next = host_data_bus_in;
          end
        end
        host_port_pkg::ST_WRITE: begin
          if (p_active) begin
            // Bus is resampled while active; last active sample wins
            hold_next = host_data_bus_in;
          end else begin
            state_next = host_port_pkg::ST_IDLE;
            par_wr_done = 1'b1;
          end
        end
        host_port_pkg::ST_READ: begin
          if (!p_active) begin
            state_next = host_port_pkg::ST_IDLE;
            par_rd_end = 1'b1;
          end
        end
        default: begin
          state_next = host_port_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (in_reset) begin
      state_reg <= host_port_pkg::ST_IDLE;
      hold_reg <= host_port_pkg::DATA_RESET;
    end else begin
      state_reg <= state_next;
      hold_reg <= hold_next;
    end
  end

  // Output group
  always_comb begin
    out_next = out_reg;
    oe_next = oe_reg;
    take_next = 1'b0;
    byte_next = byte_reg;
    dval_next = 1'b0;
    cval_next = 1'b0;
    init_next = 1'b0;
    if (par_rd_start) begin
      out_next = read_data;
      oe_next = 8'hff;
      take_next = 1'b1;
    end else if (!parallel_on || par_rd_end || state_reg != host_port_pkg::ST_READ) begin
      oe_next = 8'h00;
    end
    // Byte held aside so rx_byte only moves together with its pulse
    if (ser_done) begin
      byte_next = ser_byte;
      dval_next = data_command_select;
      cval_next = !data_command_select;
    end else if (par_wr_done) begin
      byte_next = hold_reg;
      dval_next = data_command_select;
      cval_next = !data_command_select;
    end
  end

  always_ff @(posedge clock) begin
    if (in_reset) begin
      out_reg <= host_port_pkg::DATA_RESET;
      oe_reg <= 8'h00;
      take_reg <= 1'b0;
      byte_reg <= host_port_pkg::DATA_RESET;
      dval_reg <= 1'b0;
      cval_reg <= 1'b0;
      init_reg <= 1'b1;
    end else begin
      out_reg <= out_next;
      oe_reg <= oe_next;
      take_reg <= take_next;
      byte_reg <= byte_next;
      dval_reg <= dval_next;
      cval_reg <= cval_next;
      init_reg <= init_next;
    end
  end

  assign host_data_bus_out = out_reg;
  assign host_data_bus_oe = oe_reg;
  assign read_take = take_reg;
  assign rx_byte = byte_reg;
  assign rx_data_valid = dval_reg;
  assign rx_command_valid = cval_reg;
  assign init_active = init_reg;
endmodule

// file: verification/host_port_assertions.sv
// Checker for the host port outputs
module host_port_assertions (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       reset_n,
  input wire logic       select_n,
  input wire logic       data_command_select,
  input wire logic [7:0] host_data_bus_oe,
  input wire logic       read_take,
  input wire logic       rx_data_valid,
  input wire logic       rx_command_valid,
  input wire logic       init_active
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst || !reset_n);
  // Reset checks must run while reset is high
  a_init_track: assert property (disable iff (1'b0)
    1'b1 |=> init_active == $past(rst || !reset_n)) else $error("init flag wrong");
  a_reset_quiet: assert property (disable iff (1'b0) (rst || !reset_n) |=>
    host_data_bus_oe == 8'h00 && !read_take && !rx_data_valid) else $error("busy in reset");
  a_oe_whole: assert property (host_data_bus_oe inside {8'h00, 8'hff})
    else $error("split enable");
  a_oe_take: assert property ($rose(host_data_bus_oe[0]) |-> read_take)
    else $error("drive without read");
  a_take_select: assert property (read_take |-> !$past(select_n))
    else $error("read while deselected");
  a_oe_release: assert property (select_n |=> host_data_bus_oe == 8'h00)
    else $error("bus held");
  a_data_level: assert property (rx_data_valid |-> $past(data_command_select)
    && !rx_command_valid) else $error("data level");
  a_cmd_level: assert property (rx_command_valid |-> !$past(data_command_select))
    else $error("command level");
endmodule
bind display_module_host_port host_port_assertions chk (.clock, .rst, .reset_n, .select_n,
  .data_command_select, .host_data_bus_oe, .read_take, .rx_data_valid, .rx_command_valid,
  .init_active);

// file: verification/host_mcu_model.sv
// Host controller model driving the module pins
module host_mcu_model (
  input  wire logic       clock,
  input  wire logic [7:0] host_data_bus_in,
  output logic            select_n,
  output logic            read_strobe,
  output logic            write_strobe,
  output logic            data_command_select,
  output logic      [7:0] bus_drive
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {select_n, read_strobe, write_strobe, data_command_select, bus_drive} = 12'he00;
  task automatic tick(input int n);
    repeat (n) begin @(posedge clock); #1; end
  endtask
  task automatic xfer(input bit p80, sel, rd, dc, input logic [7:0] d, output logic [7:0] q);
    select_n = !sel;
    data_command_select = dc;
    bus_drive = d;
    read_strobe = p80 ? !rd : 1'b1;
    write_strobe = rd;
    tick(3);
    q = host_data_bus_in;
    read_strobe = p80;
    write_strobe = 1'b1;
    tick(1);
    select_n = 1'b1;
    bus_drive = ~d; // Released bus must not look stable
    tick(2);
  endtask
  task automatic ser(input bit dc, input logic [7:0] d);
    select_n = 1'b0;
    data_command_select = dc;
    for (int i = 7; i >= 0; i--) begin
      bus_drive = {~bus_drive[7:2], d[i], 1'b0};
      tick(2);
      bus_drive[0] = 1'b1;
      tick(2);
    end
    bus_drive[0] = 1'b0;
    select_n = 1'b1;
    tick(2);
  endtask
endmodule

// file: verification/display_module_host_port_bench.sv
// Self-checking bench for the display module host port
module display_module_host_port_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 0, rst = 1, reset_n = 1, bus_mode_strap_a = 0, bus_mode_strap_b = 0;
  logic [7:0] read_data = 8'h00, bus_out, bus_oe, bus_drive, rx_byte, q;
  logic select_n, read_strobe, write_strobe, data_command_select, rd, sel;
  logic read_take, rx_data_valid, rx_command_valid, init_active;
  logic [31:0] seed = 32'h9957;
  int err_total = 0, n_compared = 0, n_take = 0, exp_take = 0;
  logic [8:0] expq[$];
  wire logic [7:0] bus_in = bus_oe[0] ? bus_out : bus_drive;
  always #4 clock = ~clock;
  display_module_host_port uut (.clock, .rst, .reset_n, .bus_mode_strap_a, .bus_mode_strap_b,
    .select_n, .read_strobe, .write_strobe, .data_command_select, .host_data_bus_in(bus_in),
    .host_data_bus_out(bus_out), .host_data_bus_oe(bus_oe), .read_data, .read_take, .rx_byte,
    .rx_data_valid, .rx_command_valid, .init_active);
  host_mcu_model host (.clock, .host_data_bus_in(bus_in), .select_n, .read_strobe,
    .write_strobe, .data_command_select, .bus_drive);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string name, input logic [8:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic restart(input logic a, b, pin);
    {bus_mode_strap_a, bus_mode_strap_b} = {a, b};
    if (pin) reset_n = 1'b0;
    else rst = 1'b1;
    host.tick(3);
    check("init", init_active, 1);
    {rst, reset_n} = 2'b01;
    host.tick(2);
    check("init", init_active, 0);
    {bus_mode_strap_a, bus_mode_strap_b} = ~{a, b};
  endtask
  always @(negedge clock) if (read_take !== 1'b0) n_take++;
  always @(negedge clock) if (rx_data_valid !== 1'b0 || rx_command_valid !== 1'b0) begin
    if (expq.size() == 0) check("stray byte", 9'h1, 9'h0);
    else check("byte", {rx_data_valid, rx_byte}, expq.pop_front());
  end
  initial begin
    repeat (5000) @(posedge clock);
    err_total++;
    stop_test;
  end
  initial begin
    #1;
    for (int m = 0; m < 3; m++) begin
      restart(m == 0, m == 1, m == 1);
      for (int i = 0; i < 6; i++) begin
        seed = lfsr(seed);
        read_data = seed[7:0];
        rd = (i % 3 == 1);
        sel = (i % 3 != 2);
        if (m == 2 || (sel && !rd)) expq.push_back({seed[8], seed[23:16]});
        if (m != 2 && sel && rd) exp_take++;
        if (m == 2) host.ser(seed[8], seed[23:16]);
        else host.xfer(m == 1, sel, rd, seed[8], seed[23:16], q);
        if (m != 2 && rd) check("read", q, seed[7:0]);
      end
      $display("mode %0d done", m);
    end
    check("left", 9'(expq.size()), 9'h0);
    check("take", 9'(n_take), 9'(exp_take));
    stop_test;
  end
endmodule
